/* File: hdl/ctherr_pkg.sv */
// Constants and carrier types for the card-to-host error and statistics registers.
// Assumes one 50 MHz clock domain shared with the DMA write engine.
package ctherr_pkg;
  localparam logic [11:0] OFS_RSP_ACC    = 12'hA98;
  localparam logic [11:0] OFS_RSP_CMP    = 12'hA9C;
  localparam logic [11:0] OFS_WRQ_OUT    = 12'hAA0;
  localparam logic [11:0] OFS_WPL_REN    = 12'hAA4;
  localparam logic [11:0] OFS_WRQ_LEN    = 12'hAA8;
  localparam logic [11:0] OFS_WPL_LEN    = 12'hAAC;
  localparam logic [11:0] OFS_BUF_FIRST  = 12'hAB0;
  localparam logic [11:0] OFS_BUF_LAST   = 12'hAEC;
  localparam logic [11:0] OFS_ERR_LOG    = 12'hAF0;
  localparam logic [11:0] OFS_ERR_MASK   = 12'hAF4;
  localparam logic [11:0] OFS_FATAL_LOG  = 12'hAF8;
  localparam logic [11:0] OFS_FATAL_MASK = 12'hAFC;
  localparam logic [11:0] OFS_FATAL_ACT  = 12'hB00;
  localparam logic [11:0] OFS_ERR_INT    = 12'hB04;
  localparam logic [11:0] OFS_PFCH_CFG   = 12'hB08;
  localparam logic [11:0] OFS_TIMER_TICK = 12'hB0C;
  localparam logic [11:0] OFS_RSP_DROP   = 12'hB10;
  localparam logic [11:0] OFS_RSP_ERR    = 12'hB14;
  localparam logic [11:0] OFS_DESC_REQ   = 12'hB18;
  localparam logic [11:0] OFS_DBG_A      = 12'hB1C;
  localparam logic [11:0] OFS_DBG_B      = 12'hB20;
  localparam logic [11:0] OFS_DBG_C      = 12'hB24;

  localparam int BUF_COUNT     = 16;
  localparam int MAX_DESC      = 7;
  localparam int ERR_BIT_MTY   = 0;
  localparam int ERR_BIT_LEN   = 1;
  localparam int ERR_BIT_QID   = 3;
  localparam int ERR_BIT_MSI   = 7;
  localparam int ERR_BIT_DCNT  = 9;
  localparam int ERR_BIT_CTXP  = 10;
  localparam int ERR_BIT_BYPP  = 11;
  localparam logic [31:0] ERR_LOG_MASK   = 32'h0000_1FCB;
  localparam logic [31:0] FATAL_LOG_MASK = 32'h0007_FFFB;
  localparam int ACT_WRQ_DIS   = 0;
  localparam int ACT_PAR_INV   = 1;
  localparam int INT_ARM_BIT   = 10;
  localparam int INT_COAL_BIT  = 9;
  localparam logic [31:0] INT_RW_MASK = 32'h0000_07FF;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  typedef struct packed {
    logic       rsp_accepted;
    logic       rsp_drop;
    logic       rsp_error;
    logic       rsp_completed;
    logic       wrq_out;
    logic [15:0] wrq_len;
    logic       wpl_ren;
    logic [15:0] wpl_len;
    logic       desc_req;
  } ctherr_evt_type;

  typedef struct packed {
    logic        beat_valid;
    logic        beat_last;
    logic [5:0]  empty_bytes;
    logic [15:0] beat_bytes;
    logic [15:0] ctrl_len;
    logic [10:0] ctrl_qid;
    logic [10:0] cmpt_qid;
    logic        cmpt_valid;
    logic [3:0]  desc_used;
    logic        desc_used_valid;
    logic [2:0]  pkt_port;
    logic [2:0]  ctx_port;
    logic [2:0]  byp_port;
    logic        port_check;
    logic        byp_check;
    logic        msix_fail;
  } ctherr_pkt_type;

  typedef struct packed {
    logic        coalesced;
    logic        vector;
    logic [7:0]  function_num;
  } ctherr_irq_type;

  typedef struct packed {
    logic [6:0]  eviction_threshold;
    logic [8:0]  max_queue_count;
    logic [7:0]  per_queue_depth;
    logic [7:0]  free_list_stop_threshold;
  } ctherr_pfch_type;
endpackage : ctherr_pkg

/* File: hdl/ctherr_regs.sv */
// Card-to-host error logs, statistics counters and DMA configuration registers.
// Assumes an AHB-Lite master with single word transfers; all event inputs are on clock.
`timescale 1ns/1ps
// What this block does
// RQ1: Hardware sets normal error bit on condition
// RQ2: Writing one clears a logged bit
// RQ3: Masks never gate logging
// RQ4: Normal error forwarded only when mask set
// RQ5: Fatal error handled only when mask set
// RQ6: Action bit 0 disables write requests
// RQ7: Action bit 1 inverts payload parity
// RQ8: Software arms, hardware clears on accept
// RQ9: Coalesce bit picks indirect or direct
// RQ10: Vector and function fields drive interrupt
// RQ11: Eviction starts at queue count threshold
// RQ12: Queue count never exceeds programmed maximum
// RQ13: Depth field sets entries per queue
// RQ14: Stop prefetch at free-list threshold
// RQ15: Sixteen buffer sizes, selected per queue
// RQ16: Log error above seven descriptors
// RQ17: Nonzero empty bytes before last beat
// RQ18: Log length mismatch against control sideband
// RQ19: Log queue mismatch against completion stream
// RQ20: Log context and bypass port mismatches
// RQ21: Log failed interrupt message response
// RQ22: Accepted counter counts rsp_accepted only; drop and error have own counters
// RQ23: Counters wrap, ignore writes
module ctherr_regs (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic [31:0]                    hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire ctherr_pkg::ctherr_evt_type evt,
  input  wire ctherr_pkg::ctherr_pkt_type pkt,
  input  wire logic [31:0]               fatal_src,
  input  wire logic [3:0]                buf_select,
  output logic [31:0]                    buf_size,
  input  wire logic [31:0]               debug_a,
  input  wire logic [31:0]               debug_b,
  input  wire logic [31:0]               debug_c,
  output logic [31:0]                    err_to_aggregator,
  output logic [31:0]                    fatal_to_handler,
  output logic                           wrq_disable,
  output logic                           wpl_parity_invert,
  output logic                           err_irq_req,
  output ctherr_pkg::ctherr_irq_type     err_irq_info,
  input  wire logic                      err_irq_taken,
  input  wire logic [8:0]                pfch_queue_count,
  input  wire logic [7:0]                free_list_count,
  output logic                           pfch_evict,
  output logic                           pfch_allow_fill,
  output logic                           pfch_stop,
  output ctherr_pkg::ctherr_pfch_type    pfch_cfg,
  output logic [31:0]                    timer_tick
);
  // Bus address phase capture
  logic        wr_pend_ff;
  logic [11:0] wr_addr_ff;
  logic [31:0] rdata_ff;

  logic [31:0] cnt_ff [8];
  logic [31:0] buf_ff [ctherr_pkg::BUF_COUNT];
  logic [31:0] err_log_ff;
  logic [31:0] err_mask_ff;
  logic [31:0] fatal_log_ff;
  logic [31:0] fatal_mask_ff;
  logic [1:0]  fatal_act_ff;
  logic [10:0] err_int_ff;
  logic [31:0] pfch_ff;
  logic [31:0] tick_ff;
  logic        fatal_seen_ff;
  logic [15:0] pkt_len_ff;

  wire        take      = hsel & hready & htrans[1];
  wire        take_rd   = take & ~hwrite;
  wire [11:0] rd_addr   = haddr[11:0];
  wire        do_wr     = wr_pend_ff;
  wire        wr_err    = do_wr & (wr_addr_ff == ctherr_pkg::OFS_ERR_LOG);
  wire        wr_fatal  = do_wr & (wr_addr_ff == ctherr_pkg::OFS_FATAL_LOG);
  wire        wr_emask  = do_wr & (wr_addr_ff == ctherr_pkg::OFS_ERR_MASK);
  wire        wr_fmask  = do_wr & (wr_addr_ff == ctherr_pkg::OFS_FATAL_MASK);
  wire        wr_act    = do_wr & (wr_addr_ff == ctherr_pkg::OFS_FATAL_ACT);
  wire        wr_int    = do_wr & (wr_addr_ff == ctherr_pkg::OFS_ERR_INT);
  wire        wr_pfch   = do_wr & (wr_addr_ff == ctherr_pkg::OFS_PFCH_CFG);
  wire        wr_tick   = do_wr & (wr_addr_ff == ctherr_pkg::OFS_TIMER_TICK);
  wire        wr_buf    = do_wr & (wr_addr_ff >= ctherr_pkg::OFS_BUF_FIRST)
                                & (wr_addr_ff <= ctherr_pkg::OFS_BUF_LAST);
  wire [3:0]  wr_buf_ix = 4'((wr_addr_ff - ctherr_pkg::OFS_BUF_FIRST) >> 2);
  wire [3:0]  rd_buf_ix = 4'((rd_addr - ctherr_pkg::OFS_BUF_FIRST) >> 2);

  // Error detection from the packet side
  wire [15:0] nxt_pkt_len = pkt.beat_valid ? (pkt.beat_last ? 16'h0000 : pkt_len_ff + pkt.beat_bytes) : pkt_len_ff;
  wire [15:0] pkt_total   = pkt_len_ff + pkt.beat_bytes;
  logic [31:0] err_hit;
  always_comb begin
    err_hit = 32'h0000_0000;
    err_hit[ctherr_pkg::ERR_BIT_MTY]  = pkt.beat_valid & ~pkt.beat_last & (pkt.empty_bytes != 6'h00); // RQ17
    err_hit[ctherr_pkg::ERR_BIT_LEN]  = pkt.beat_valid & pkt.beat_last & (pkt_total != pkt.ctrl_len); // RQ18
    err_hit[ctherr_pkg::ERR_BIT_QID]  = pkt.cmpt_valid & (pkt.ctrl_qid != pkt.cmpt_qid); // RQ19
    err_hit[ctherr_pkg::ERR_BIT_MSI]  = pkt.msix_fail; // RQ21
    err_hit[ctherr_pkg::ERR_BIT_DCNT] = pkt.desc_used_valid & (pkt.desc_used > 4'(ctherr_pkg::MAX_DESC)); // RQ16
    err_hit[ctherr_pkg::ERR_BIT_CTXP] = pkt.port_check & (pkt.pkt_port != pkt.ctx_port); // RQ20
    err_hit[ctherr_pkg::ERR_BIT_BYPP] = pkt.byp_check & (pkt.pkt_port != pkt.byp_port); // RQ20
  end
  wire [31:0] fatal_hit = fatal_src & ctherr_pkg::FATAL_LOG_MASK;

  // Set wins over a same-cycle write-one clear
  wire [31:0] nxt_err_log   = ((err_log_ff & ~(wr_err ? hwdata : 32'h0000_0000)) | err_hit)
                              & ctherr_pkg::ERR_LOG_MASK; // RQ1 RQ2 RQ3
  wire [31:0] nxt_fatal_log = (fatal_log_ff & ~(wr_fatal ? hwdata : 32'h0000_0000)) | fatal_hit; // RQ2 RQ3
  wire        fatal_now     = |(fatal_hit & fatal_mask_ff); // RQ5

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
    end else begin
      wr_pend_ff <= take & hwrite;
      wr_addr_ff <= haddr[11:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_log_ff    <= ctherr_pkg::REG_RESET;
      fatal_log_ff  <= ctherr_pkg::REG_RESET;
      err_mask_ff   <= ctherr_pkg::REG_RESET;
      fatal_mask_ff <= ctherr_pkg::REG_RESET;
      pkt_len_ff    <= 16'h0000;
    end else begin
      err_log_ff   <= nxt_err_log;
      fatal_log_ff <= nxt_fatal_log;
      pkt_len_ff   <= nxt_pkt_len;
      if (wr_emask) err_mask_ff <= hwdata;
      if (wr_fmask) fatal_mask_ff <= hwdata;
    end
  end

  // Fatal event stays latched until reset; writing zero to the action register releases the actions
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fatal_act_ff  <= 2'h0;
      fatal_seen_ff <= 1'b0;
      err_int_ff    <= 11'h000;
      pfch_ff       <= ctherr_pkg::REG_RESET;
      tick_ff       <= ctherr_pkg::REG_RESET;
    end else begin
      if (fatal_now) fatal_seen_ff <= 1'b1;
      if (wr_act) fatal_act_ff <= hwdata[1:0];
      if (wr_int) err_int_ff <= hwdata[10:0];
      else if (err_irq_taken) err_int_ff[ctherr_pkg::INT_ARM_BIT] <= 1'b0; // RQ8
      if (wr_pfch) pfch_ff <= hwdata;
      if (wr_tick) tick_ff <= hwdata;
    end
  end

  // Buffer-size table and event counters
  wire [7:0]  cnt_inc = {evt.desc_req, evt.rsp_error, evt.rsp_drop, evt.wpl_ren,
                         evt.wrq_out, evt.rsp_completed, evt.rsp_accepted, 1'b0};
  wire [31:0] cnt_add [8];
  assign cnt_add[0] = {16'h0000, evt.wrq_out ? evt.wrq_len : 16'h0000};
  assign cnt_add[1] = 32'(cnt_inc[1]);
  assign cnt_add[2] = 32'(cnt_inc[2]);
  assign cnt_add[3] = 32'(cnt_inc[3]);
  assign cnt_add[4] = 32'(cnt_inc[4]);
  assign cnt_add[5] = 32'(cnt_inc[5]);
  assign cnt_add[6] = 32'(cnt_inc[6]);
  assign cnt_add[7] = {16'h0000, evt.wpl_ren ? evt.wpl_len : 16'h0000};
  // 0 wrq len, 1 accepted, 2 completed, 3 wrq out, 4 ren, 5 drop, 6 error, 7 wpl len, desc req separate
  logic [31:0] desc_req_ff;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_cnt
      always_ff @(posedge clock or posedge rst) begin
        if (rst) cnt_ff[gi] <= ctherr_pkg::REG_RESET;
        else cnt_ff[gi] <= cnt_ff[gi] + cnt_add[gi]; // RQ22 RQ23
      end
    end
    for (gi = 0; gi < ctherr_pkg::BUF_COUNT; gi++) begin : g_buf
      always_ff @(posedge clock or posedge rst) begin
        if (rst) buf_ff[gi] <= ctherr_pkg::REG_RESET;
        else if (wr_buf && wr_buf_ix == 4'(gi)) buf_ff[gi] <= hwdata; // RQ15
      end
    end
  endgenerate
  always_ff @(posedge clock or posedge rst) begin
    if (rst) desc_req_ff <= ctherr_pkg::REG_RESET;
    else desc_req_ff <= desc_req_ff + 32'(cnt_inc[7]); // RQ23
  end

  // Read mux
  logic [31:0] rd_val;
  always_comb begin
    unique case (rd_addr)
      ctherr_pkg::OFS_RSP_ACC:    rd_val = cnt_ff[1];
      ctherr_pkg::OFS_RSP_CMP:    rd_val = cnt_ff[2];
      ctherr_pkg::OFS_WRQ_OUT:    rd_val = cnt_ff[3];
      ctherr_pkg::OFS_WPL_REN:    rd_val = cnt_ff[4];
      ctherr_pkg::OFS_WRQ_LEN:    rd_val = cnt_ff[0];
      ctherr_pkg::OFS_WPL_LEN:    rd_val = cnt_ff[7];
      ctherr_pkg::OFS_ERR_LOG:    rd_val = err_log_ff;
      ctherr_pkg::OFS_ERR_MASK:   rd_val = err_mask_ff;
      ctherr_pkg::OFS_FATAL_LOG:  rd_val = fatal_log_ff;
      ctherr_pkg::OFS_FATAL_MASK: rd_val = fatal_mask_ff;
      ctherr_pkg::OFS_FATAL_ACT:  rd_val = {30'h0000_0000, fatal_act_ff};
      ctherr_pkg::OFS_ERR_INT:    rd_val = {21'h00_0000, err_int_ff};
      ctherr_pkg::OFS_PFCH_CFG:   rd_val = pfch_ff;
      ctherr_pkg::OFS_TIMER_TICK: rd_val = tick_ff;
      ctherr_pkg::OFS_RSP_DROP:   rd_val = cnt_ff[5];
      ctherr_pkg::OFS_RSP_ERR:    rd_val = cnt_ff[6];
      ctherr_pkg::OFS_DESC_REQ:   rd_val = desc_req_ff;
      ctherr_pkg::OFS_DBG_A:      rd_val = {1'b0, debug_a[30:0]};
      ctherr_pkg::OFS_DBG_B:      rd_val = {1'b0, debug_b[30:0]};
      ctherr_pkg::OFS_DBG_C:      rd_val = {2'h0, debug_c[29:0]};
      default: begin
        if (rd_addr >= ctherr_pkg::OFS_BUF_FIRST && rd_addr <= ctherr_pkg::OFS_BUF_LAST) rd_val = buf_ff[rd_buf_ix];
        else rd_val = 32'h0000_0000;
      end
    endcase
  end
  // Captured at the address phase: a read right behind a write sees the old value
  always_ff @(posedge clock or posedge rst) begin
    if (rst) rdata_ff <= 32'h0000_0000;
    else if (take_rd) rdata_ff <= rd_val;
  end

  // Zero wait states; unmapped addresses read zero, writes dropped
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;

  assign err_to_aggregator = err_log_ff & err_mask_ff; // RQ4
  assign fatal_to_handler  = fatal_log_ff & fatal_mask_ff; // RQ5
  assign wrq_disable       = fatal_seen_ff & fatal_act_ff[ctherr_pkg::ACT_WRQ_DIS]; // RQ6
  assign wpl_parity_invert = fatal_seen_ff & fatal_act_ff[ctherr_pkg::ACT_PAR_INV]; // RQ7
  assign err_irq_req       = err_int_ff[ctherr_pkg::INT_ARM_BIT] & (|err_to_aggregator); // RQ8
  // One driver for the whole struct
  assign err_irq_info      = '{coalesced:    err_int_ff[ctherr_pkg::INT_COAL_BIT], // RQ9
                               vector:       err_int_ff[8], // RQ10
                               function_num: err_int_ff[7:0]}; // RQ10
  assign pfch_cfg          = pfch_ff; // RQ13
  assign pfch_evict        = pfch_queue_count >= {2'h0, pfch_ff[31:25]}; // RQ11
  assign pfch_allow_fill   = (pfch_queue_count < pfch_ff[24:16]) & ~pfch_stop; // RQ12 RQ14
  assign pfch_stop         = free_list_count <= pfch_ff[7:0]; // RQ14
  assign buf_size          = buf_ff[buf_select]; // RQ15
  assign timer_tick        = tick_ff;

  a_err_log_set: assert property (@(posedge clock) disable iff (rst) // RQ1
    |err_hit |-> ##1 ((err_log_ff & $past(err_hit)) == $past(err_hit)))
    else $error("error log bit not set");
  a_err_w1c: assert property (@(posedge clock) disable iff (rst) // RQ2
    (wr_err && err_hit == 32'h0) |=> ((err_log_ff & $past(hwdata)) == 32'h0))
    else $error("error log bit not cleared");
  a_mask_forward: assert property (@(posedge clock) disable iff (rst) // RQ4
    (err_to_aggregator & ~err_mask_ff) == 32'h0)
    else $error("unmasked error forwarded");
  a_wrq_stop: assert property (@(posedge clock) disable iff (rst) // RQ6
    (fatal_now && fatal_act_ff[0] && !wr_act) |=> wrq_disable)
    else $error("write requests not disabled");
  a_par_inv: assert property (@(posedge clock) disable iff (rst) // RQ7
    (fatal_now && fatal_act_ff[1] && !wr_act) |=> wpl_parity_invert)
    else $error("parity not inverted");
  a_arm_clear: assert property (@(posedge clock) disable iff (rst) // RQ8
    (err_irq_taken && !wr_int) |=> !err_int_ff[10])
    else $error("arm bit not cleared");
  a_desc_cnt: assert property (@(posedge clock) disable iff (rst) // RQ16
    (pkt.desc_used_valid && pkt.desc_used > 4'h7) |=> err_log_ff[9])
    else $error("descriptor count error missed");
  a_cnt_step: assert property (@(posedge clock) disable iff (rst) // RQ22
    evt.rsp_accepted |=> cnt_ff[1] == $past(cnt_ff[1]) + 32'h1)
    else $error("accepted counter did not step");

  // Seen from the outputs and the error log; a same-cycle mask write is left out
  a_mask_pass: assert property (@(posedge clock) disable iff (rst) // RQ4
    (|(err_hit & err_mask_ff) && !wr_emask) |=> |err_to_aggregator)
    else $error("enabled error not forwarded");
  a_log_unmasked: assert property (@(posedge clock) disable iff (rst) // RQ3
    (|(err_hit & ~err_mask_ff) && !wr_emask) |=> |(err_log_ff & ~err_mask_ff))
    else $error("masked error not logged");
  a_fatal_forward: assert property (@(posedge clock) disable iff (rst) // RQ5
    (fatal_now && !wr_fmask) |=> |fatal_to_handler)
    else $error("fatal error not handed on");

  a_qid_log: assert property (@(posedge clock) disable iff (rst) // RQ19
    (pkt.cmpt_valid && pkt.ctrl_qid != pkt.cmpt_qid) |=> err_log_ff[ctherr_pkg::ERR_BIT_QID])
    else $error("queue mismatch not logged");
  a_len_log: assert property (@(posedge clock) disable iff (rst) // RQ18
    (pkt.beat_valid && pkt.beat_last && pkt_total != pkt.ctrl_len) |=> err_log_ff[ctherr_pkg::ERR_BIT_LEN])
    else $error("length mismatch not logged");

  a_cnt_readonly: assert property (@(posedge clock) disable iff (rst) // RQ23
    (wr_pend_ff && wr_addr_ff == ctherr_pkg::OFS_RSP_ACC && !evt.rsp_accepted) |=> $stable(cnt_ff[1]))
    else $error("counter changed by a write");
  a_buf_select: assert property (@(posedge clock) disable iff (rst) // RQ15
    (wr_buf && buf_select == wr_buf_ix) ##1 $stable(buf_select) |-> buf_size == $past(hwdata))
    else $error("selected buffer size wrong");

  c_err_logged: cover property (@(posedge clock) disable iff (rst) err_hit[0] ##[1:20] wr_err);
  c_pfch_stop: cover property (@(posedge clock) disable iff (rst) pfch_evict && pfch_stop);
  c_buf_last: cover property (@(posedge clock) disable iff (rst) wr_buf && wr_buf_ix == 4'hF);
  c_fatal: cover property (@(posedge clock) disable iff (rst) fatal_now && fatal_act_ff == 2'h3);
  c_irq_taken: cover property (@(posedge clock) disable iff (rst) err_irq_req ##1 err_irq_taken);
endmodule : ctherr_regs

/* File: verification/ctherr_regs_tb_top.sv */
// Self-checking bench for the card-to-host error and statistics register block.
// Assumes one clock, hreadyout fed back as hready, and event inputs sampled as one-cycle pulses.
`timescale 1ns/1ps
module ctherr_regs_tb_top;
  logic                        clock;
  logic                        rst;
  logic                        hsel;
  logic [31:0]                 haddr;
  logic [1:0]                  htrans;
  logic                        hwrite;
  logic [31:0]                 hwdata;
  logic [31:0]                 hrdata;
  logic                        hreadyout;
  logic                        hresp;
  ctherr_pkg::ctherr_evt_type  evt;
  ctherr_pkg::ctherr_pkt_type  pkt;
  logic [31:0]                 fatal_src;
  logic [3:0]                  buf_select;
  logic [31:0]                 buf_size;
  logic [31:0]                 dbg;
  logic [31:0]                 err_to_aggregator;
  logic [31:0]                 fatal_to_handler;
  logic                        wrq_disable;
  logic                        wpl_parity_invert;
  logic                        err_irq_req;
  ctherr_pkg::ctherr_irq_type  err_irq_info;
  logic                        err_irq_taken;
  logic [8:0]                  pfch_queue_count;
  logic [7:0]                  free_list_count;
  logic                        pfch_evict;
  logic                        pfch_allow_fill;
  logic                        pfch_stop;
  ctherr_pkg::ctherr_pfch_type pfch_cfg;
  logic [31:0]                 timer_tick;
  int                          n_mismatch;
  int                          n_checks;

  ctherr_regs DUT (
    .clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .evt, .pkt, .fatal_src, .buf_select, .buf_size, .debug_a(dbg), .debug_b(dbg),
    .debug_c(dbg), .err_to_aggregator, .fatal_to_handler, .wrq_disable, .wpl_parity_invert, .err_irq_req,
    .err_irq_info, .err_irq_taken, .pfch_queue_count, .free_list_count, .pfch_evict, .pfch_allow_fill,
    .pfch_stop, .pfch_cfg, .timer_tick
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Bounded so a stuck slave ends the run instead of hanging it
  task automatic wait_rdy;
    int i;
    i = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin
        n_mismatch++;
        finish_test;
      end
      @(posedge clock);
    end
  endtask : wait_rdy

  task automatic xfer(input logic [11:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0000_0000, q);
    chk(q, exp, what);
  endtask : rd_chk

  task automatic tick2;
    repeat (2) @(posedge clock);
  endtask : tick2

  task automatic do_reset;
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
  endtask : do_reset

  // One error pulse, then read, clear by writing ones, read again
  task automatic pkt_case(input ctherr_pkg::ctherr_pkt_type p, input logic [31:0] exp, input string what);
    pkt <= p;
    @(posedge clock);
    pkt <= '0;
    @(posedge clock);
    rd_chk(ctherr_pkg::OFS_ERR_LOG, exp, what);
    wr(ctherr_pkg::OFS_ERR_LOG, exp);
    rd_chk(ctherr_pkg::OFS_ERR_LOG, 32'h0000_0000, "log after clear");
  endtask : pkt_case

  task automatic t_err_log;
    pkt_case('{cmpt_valid:1'b1, ctrl_qid:11'h005, cmpt_qid:11'h006, default:'0}, 32'h0000_0008, "qid");
    pkt_case('{cmpt_valid:1'b1, ctrl_qid:11'h005, cmpt_qid:11'h005, default:'0}, 32'h0000_0000, "qid ok");
    pkt_case('{msix_fail:1'b1, default:'0}, 32'h0000_0080, "msix");
    pkt_case('{desc_used_valid:1'b1, desc_used:4'h8, default:'0}, 32'h0000_0200, "desc 8");
    pkt_case('{desc_used_valid:1'b1, desc_used:4'h7, default:'0}, 32'h0000_0000, "desc 7");
    pkt_case('{port_check:1'b1, pkt_port:3'h1, ctx_port:3'h2, default:'0}, 32'h0000_0400, "ctx port");
    pkt_case('{byp_check:1'b1, pkt_port:3'h3, byp_port:3'h4, default:'0}, 32'h0000_0800, "byp port");
    pkt_case('{beat_valid:1'b1, empty_bytes:6'h03, default:'0}, 32'h0000_0001, "empty bytes");
    pkt_case('{beat_valid:1'b1, beat_last:1'b1, beat_bytes:16'h0040, ctrl_len:16'h0040, default:'0}, 32'h0, "len");
    pkt_case('{beat_valid:1'b1, beat_last:1'b1, beat_bytes:16'h0040, ctrl_len:16'h0080, default:'0}, 32'h2, "len");
  endtask : t_err_log

  task automatic t_irq;
    wr(ctherr_pkg::OFS_ERR_MASK, 32'h0000_0080);
    pkt <= '{msix_fail:1'b1, cmpt_valid:1'b1, cmpt_qid:11'h001, default:'0};
    @(posedge clock);
    pkt <= '0;
    @(posedge clock);
    rd_chk(ctherr_pkg::OFS_ERR_LOG, 32'h0000_0088, "log ignores mask");
    chk(err_to_aggregator, 32'h0000_0080, "forwarded");
    chk({31'h0, err_irq_req}, 32'h0, "unarmed");
    wr(ctherr_pkg::OFS_ERR_INT, 32'h0000_075A);
    tick2;
    chk({22'h0, err_irq_info}, 32'h0000_035A, "indirect info");
    chk({31'h0, err_irq_req}, 32'h1, "armed");
    err_irq_taken <= 1'b1;
    @(posedge clock);
    err_irq_taken <= 1'b0;
    tick2;
    rd_chk(ctherr_pkg::OFS_ERR_INT, 32'h0000_035A, "arm cleared");
    chk({31'h0, err_irq_req}, 32'h0, "taken");
    wr(ctherr_pkg::OFS_ERR_INT, 32'h0000_00A5);
    wr(ctherr_pkg::OFS_ERR_LOG, 32'h0000_0088);
    tick2;
    chk({22'h0, err_irq_info}, 32'h0000_00A5, "direct info");
    chk(err_to_aggregator, 32'h0, "cleared");
  endtask : t_irq

  task automatic t_counters;
    evt <= '{rsp_accepted:1'b1, rsp_drop:1'b1, rsp_error:1'b1, wrq_out:1'b1, wrq_len:16'h0100, default:'0};
    repeat (3) @(posedge clock);
    evt <= '{desc_req:1'b1, wpl_ren:1'b1, wpl_len:16'h0020, rsp_completed:1'b1, default:'0};
    @(posedge clock);
    evt <= '0;
    wr(ctherr_pkg::OFS_RSP_ACC, 32'hFFFF_FFFF);
    rd_chk(ctherr_pkg::OFS_RSP_ACC, 32'h3, "accepted");
    rd_chk(ctherr_pkg::OFS_RSP_DROP, 32'h3, "drop");
    rd_chk(ctherr_pkg::OFS_RSP_ERR, 32'h3, "error");
    rd_chk(ctherr_pkg::OFS_WRQ_OUT, 32'h3, "wrq");
    rd_chk(ctherr_pkg::OFS_WPL_REN, 32'h1, "wpl ren");
    rd_chk(ctherr_pkg::OFS_WRQ_LEN, 32'h0300, "wrq len");
    rd_chk(ctherr_pkg::OFS_WPL_LEN, 32'h0020, "wpl len");
    rd_chk(ctherr_pkg::OFS_DESC_REQ, 32'h1, "desc req");
    rd_chk(ctherr_pkg::OFS_RSP_CMP, 32'h1, "completed");
  endtask : t_counters

  task automatic t_cfg;
    for (int i = 0; i < 16; i++)
      wr(ctherr_pkg::OFS_BUF_FIRST + 12'(4 * i), 32'(32'h1000 + i));
    rd_chk(ctherr_pkg::OFS_BUF_LAST, 32'h0000_100F, "last buffer");
    buf_select <= 4'h9;
    tick2;
    chk(buf_size, 32'h0000_1009, "selected buffer");
    wr(ctherr_pkg::OFS_PFCH_CFG, 32'h2828_0810);
    pfch_queue_count <= 9'd19;
    free_list_count <= 8'd17;
    tick2;
    chk(pfch_cfg, 32'h2828_0810, "prefetch fields");
    chk({29'h0, pfch_evict, pfch_stop, pfch_allow_fill}, 32'h1, "below thresholds");
    pfch_queue_count <= 9'd20;
    free_list_count <= 8'd16;
    tick2;
    chk({30'h0, pfch_evict, pfch_stop}, 32'h3, "at thresholds");
    free_list_count <= 8'd100;
    pfch_queue_count <= 9'd40;
    tick2;
    chk({31'h0, pfch_allow_fill}, 32'h0, "at maximum");
    wr(ctherr_pkg::OFS_TIMER_TICK, 32'hA5A5_5A5A);
    rd_chk(ctherr_pkg::OFS_TIMER_TICK, 32'hA5A5_5A5A, "timer tick");
    chk(timer_tick, 32'hA5A5_5A5A, "tick output");
    rd_chk(ctherr_pkg::OFS_DBG_A, 32'h7FFF_FFFF, "debug a");
    rd_chk(ctherr_pkg::OFS_DBG_B, 32'h7FFF_FFFF, "debug b");
    rd_chk(ctherr_pkg::OFS_DBG_C, 32'h3FFF_FFFF, "debug c");
    rd_chk(12'hB28, 32'h0, "unmapped");
  endtask : t_cfg

  task automatic t_fatal;
    wr(ctherr_pkg::OFS_FATAL_ACT, 32'h3);
    fatal_src <= 32'h8000_0006;
    @(posedge clock);
    fatal_src <= 32'h0;
    rd_chk(ctherr_pkg::OFS_FATAL_LOG, 32'h2, "fatal log");
    chk({fatal_to_handler[31:2], wrq_disable, wpl_parity_invert}, 32'h0, "unmasked fatal");
    wr(ctherr_pkg::OFS_FATAL_MASK, 32'h2);
    fatal_src <= 32'h2;
    @(posedge clock);
    fatal_src <= 32'h0;
    tick2;
    chk(fatal_to_handler, 32'h2, "to handler");
    chk({30'h0, wrq_disable, wpl_parity_invert}, 32'h3, "actions");
    wr(ctherr_pkg::OFS_FATAL_LOG, 32'h2);
    rd_chk(ctherr_pkg::OFS_FATAL_LOG, 32'h0, "fatal cleared");
  endtask : t_fatal

  initial begin
    {rst, hsel, haddr, htrans, hwrite, hwdata, err_irq_taken} = '0;
    {evt, pkt, fatal_src, buf_select, pfch_queue_count, free_list_count} = '0;
    dbg = 32'hFFFF_FFFF;
    n_mismatch = 0;
    n_checks = 0;
    do_reset;
    rd_chk(ctherr_pkg::OFS_ERR_MASK, 32'h0, "mask reset");
    rd_chk(ctherr_pkg::OFS_PFCH_CFG, 32'h0, "prefetch reset");
    chk({31'h0, hresp}, 32'h0, "okay response");
    t_err_log;
    t_irq;
    t_counters;
    t_cfg;
    t_fatal;
    do_reset;
    chk({30'h0, wrq_disable, wpl_parity_invert}, 32'h0, "actions after reset");
    rd_chk(ctherr_pkg::OFS_RSP_ACC, 32'h0, "counter reset");
    finish_test;
  end
endmodule : ctherr_regs_tb_top
